// ===== hw/ppo_pkg.sv
package ppo_pkg;
    localparam int          NUM_PORTS         = 6;
    localparam int          PORT3_IDX         = 2;
    localparam int          PORT4_IDX         = 3;
    localparam logic [15:0] ADDR_LOCKOUT      = 16'h30e1;
    localparam logic [15:0] ADDR_MIN_WIDTH    = 16'h30ea;
    localparam logic [15:0] ADDR_DBL_WINDOW   = 16'h30eb;
    localparam logic [15:0] ADDR_PORT_SPLIT   = 16'h3c48;
    localparam logic [15:0] ADDR_GLOBAL_SPLIT = 16'h4141;
    localparam logic [15:0] ADDR_P3_PINSEL    = 16'h416e;
    localparam logic [15:0] ADDR_P4_PINSEL    = 16'h416f;
    localparam logic [15:0] ADDR_OC_STATUS    = 16'h3100;
    localparam logic [15:0] ADDR_PWR_ENABLE   = 16'h3101;
    localparam logic [7:0]  RST_LOCKOUT       = 8'h0a;
    localparam logic [7:0]  RST_DBL_WINDOW    = 8'h14;
    localparam logic [7:0]  RST_MIN_WIDTH     = 8'h01;
    localparam logic [7:0]  RST_ZERO          = 8'h00;
    localparam logic [7:0]  MASK_MIN_WIDTH    = 8'h0f;
    localparam logic [7:0]  MASK_GLOBAL       = 8'h01;
    localparam logic [7:0]  MASK_PORT_SPLIT   = 8'h60;
    localparam int          BIT_SPLIT_P3      = 5;
    localparam int          BIT_SPLIT_P4      = 6;
    localparam int          BIT_GLOBAL_SPLIT  = 0;
    localparam logic [7:0]  SEL_P3_OPT_A      = 8'h42;
    localparam logic [7:0]  SEL_P3_OPT_B      = 8'h05;
    localparam logic [7:0]  SEL_P4_OPT_A      = 8'h06;
    localparam logic [7:0]  SEL_P4_OPT_B      = 8'h04;
    localparam int          CLK_HZ            = 20_000_000;
    localparam int          TICK_MS           = 1;
    localparam int          TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ppo_req_s;

    typedef struct packed {
        logic [7:0] lockout;
        logic [7:0] dbl_window;
        logic [3:0] min_width;
    } ppo_timing_s;
endpackage

// ===== hw/ppo_port.sv
`timescale 1ns/100ps
`default_nettype none
module ppo_port (
    input  wire logic                 mclk,      // core clock
    input  wire logic                 srst,      // sync reset
    input  wire logic                 tick,      // 1 ms tick
    input  wire logic                 pwr_en,    // port power on
    input  wire logic                 pin_low,   // synchronised low sense
    input  wire logic                 oc_clr,    // software clear pulse
    input  wire ppo_pkg::ppo_timing_s tim,       // timing setup
    output logic                      oc_flag,   // latched overcurrent
    output logic                      oc_event   // pulse when flag rises
);
    import ppo_pkg::*;
    logic [7:0] lock_ff, win_ff, wid_ff;
    logic       armed_ff, prev_low_ff, first_ff, flag_ff, pwr_ff;
    wire pwr_rise = pwr_en && !pwr_ff;
    wire sensing  = pwr_en && armed_ff;
    wire new_grp  = sensing && pin_low && !prev_low_ff;
    // width counts whole ticks, so a pulse is qualified to within 1 ms
    wire single_hit = sensing && pin_low && (wid_ff >= {4'h0, tim.min_width});
    wire double_hit = new_grp && first_ff;
    wire hit = single_hit || double_hit;
    always_ff @(posedge mclk) begin
        pwr_ff <= srst ? 1'b0 : pwr_en;
        if (srst || !pwr_en || pwr_rise) begin
            lock_ff  <= tim.lockout;
            armed_ff <= 1'b0;
        end else if (!armed_ff && tick) begin
            lock_ff  <= lock_ff - 8'h01;
            armed_ff <= (lock_ff <= 8'h01);
        end
        prev_low_ff <= !srst && sensing && pin_low;
        if (srst || !sensing || !pin_low) wid_ff <= '0;
        else if (tick && wid_ff != 8'hff) wid_ff <= wid_ff + 8'h01;
        if (srst || !sensing) begin
            first_ff <= 1'b0;
            win_ff   <= '0;
        end else if (new_grp && !first_ff) begin
            first_ff <= 1'b1;
            win_ff   <= tim.dbl_window;
        end else if (first_ff && tick) begin
            win_ff   <= win_ff - 8'h01;
            first_ff <= (win_ff > 8'h01);
        end
        // set beats clear in the same cycle
        if (srst || pwr_rise) flag_ff <= 1'b0;
        else if (hit) flag_ff <= 1'b1;
        else if (oc_clr) flag_ff <= 1'b0;
    end
    assign oc_flag  = flag_ff;
    assign oc_event = hit && !flag_ff;
    lock_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        !armed_ff |-> !hit) else $error("overcurrent during lockout");
    off_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        !pwr_en |-> !hit) else $error("overcurrent while unpowered");
    flag_hold_a: assert property (@(posedge mclk) disable iff (srst)
        hit |=> flag_ff) else $error("flag not set after hit");
    set_wins_a: assert property (@(posedge mclk) disable iff (srst)
        (hit && oc_clr && !pwr_rise) |=> flag_ff) else $error("clear beat set");
    cv_double: cover property (@(posedge mclk) double_hit);
    cv_single: cover property (@(posedge mclk) single_hit && !double_hit);
endmodule
`default_nettype wire

// ===== hw/ppo_tick.sv
`timescale 1ns/100ps
`default_nettype none
module ppo_tick #(
    parameter int CYCLES = ppo_pkg::TICK_CYCLES
) (
    input  wire logic mclk,  // core clock
    input  wire logic srst,  // sync reset
    output logic      tick   // one-cycle 1 ms pulse
);
    import ppo_pkg::*;
    logic [$clog2(CYCLES)-1:0] cnt_ff;
    wire last = (cnt_ff == ($clog2(CYCLES))'(CYCLES - 1));
    always_ff @(posedge mclk) begin
        if (srst || last) cnt_ff <= '0;
        else cnt_ff <= cnt_ff + 1'b1;
    end
    assign tick = last;
    tick_period_a: assert property (@(posedge mclk) disable iff (srst)
        tick |=> !tick [*8]) else $error("tick repeated too soon");
endmodule
`default_nettype wire

// ===== hw/ppo_top.sv
// Overview of operation
// - double low pulse counts only inside programmable window, default 20 ms
// - ignore overcurrent for lockout time after power on, default 10 ms
// - power off drives pin low; power on releases with pull-up
// - low on powered pin (open fuse) is overcurrent
// - only ports 3 and 4 may split
// - split port keeps its control pin for the 2.0 side
// - split enables power output on a selected general pin
// - split power output has no overcurrent sensing
// - port 3 pin select 0x42 option A, 0x05 option B
// - port 4 pin select 0x06 option A, 0x04 option B
// - per-port split register resets zero, bit5 port3, bit6 port4
// - split needs global enable bit 0 as well
// - split port runs 2.0 and 3.x sides as independent ports
// - sample pin only while port enabled
// - low for minimum single pulse width flags overcurrent
// - two low groups within window flag overcurrent
// - minimum width field four bits, codes 0 to 15 ms
`timescale 1ns/100ps
`default_nettype none
module ppo_top #(
    parameter int NPORT = ppo_pkg::NUM_PORTS,
    parameter int TICKC = ppo_pkg::TICK_CYCLES
) (
    input  wire logic              mclk,          // 20 MHz core clock
    input  wire logic              srst,          // sync reset, high
    input  wire ppo_pkg::ppo_req_s cfg_req,       // config register access
    output logic [7:0]             cfg_rdata,     // registered read data
    input  wire logic [NPORT-1:0]  pwr_req,       // hub port power requests
    input  wire logic [NPORT-1:0]  ss_pwr_req,    // 3.x side power requests
    input  wire logic [NPORT-1:0]  sense_in,      // port_power_sense_pin input
    output logic [NPORT-1:0]       sense_out,     // port_power_sense_pin output
    output logic [NPORT-1:0]       sense_oe,      // port_power_sense_pin enable
    output logic [NPORT-1:0]       sense_pullup,  // pull-up enable
    output logic                   port3_pin_option_a, // split power port 3 A
    output logic                   port3_pin_option_b, // split power port 3 B
    output logic                   port4_pin_option_a, // split power port 4 A
    output logic                   port4_pin_option_b, // split power port 4 B
    output logic [NPORT-1:0]       split_active,  // port runs split
    output logic [NPORT-1:0]       oc_flag,       // latched overcurrent
    output logic [NPORT-1:0]       oc_event       // overcurrent event pulse
);
    import ppo_pkg::*;
    logic [7:0] lock_ff, win_ff, minw_ff, split_ff, glob_ff, p3sel_ff, p4sel_ff;
    logic [7:0] rdata_ff;
    logic [NPORT-1:0] s1_ff, s2_ff, sspwr_ff;
    logic [NPORT-1:0] clr;
    logic tick;
    ppo_timing_s tim;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_a);
        hit = (a == reg_a);
    endfunction

    wire wr = cfg_req.wr;
    wire [15:0] ad = cfg_req.addr;
    wire [7:0] wd = cfg_req.wdata;
    wire glob_on = glob_ff[BIT_GLOBAL_SPLIT];
    wire p3_split = glob_on && split_ff[BIT_SPLIT_P3];
    wire p4_split = glob_on && split_ff[BIT_SPLIT_P4];

    always_ff @(posedge mclk) begin
        if (srst) begin
            lock_ff  <= RST_LOCKOUT;
            win_ff   <= RST_DBL_WINDOW;
            minw_ff  <= RST_MIN_WIDTH;
            split_ff <= RST_ZERO;
            glob_ff  <= RST_ZERO;
            p3sel_ff <= RST_ZERO;
            p4sel_ff <= RST_ZERO;
        end else if (wr) begin
            if (hit(ad, ADDR_LOCKOUT))      lock_ff  <= wd;
            if (hit(ad, ADDR_DBL_WINDOW))   win_ff   <= wd;
            if (hit(ad, ADDR_MIN_WIDTH))    minw_ff  <= wd & MASK_MIN_WIDTH;
            // bit 0 and reserved bits never stick
            if (hit(ad, ADDR_PORT_SPLIT))   split_ff <= wd & MASK_PORT_SPLIT;
            if (hit(ad, ADDR_GLOBAL_SPLIT)) glob_ff  <= wd & MASK_GLOBAL;
            if (hit(ad, ADDR_P3_PINSEL))    p3sel_ff <= wd;
            if (hit(ad, ADDR_P4_PINSEL))    p4sel_ff <= wd;
        end
    end

    // clear by writing ones to the status address
    generate
        for (genvar i = 0; i < NPORT; i++) begin : g_clr
            assign clr[i] = wr && hit(ad, ADDR_OC_STATUS) && wd[i];
        end
    endgenerate

    wire [7:0] oc_byte  = 8'(oc_flag);
    wire [7:0] pwr_byte = 8'(pwr_req);
    wire [7:0] rd_mux =
        hit(ad, ADDR_LOCKOUT)      ? lock_ff  :
        hit(ad, ADDR_DBL_WINDOW)   ? win_ff   :
        hit(ad, ADDR_MIN_WIDTH)    ? minw_ff  :
        hit(ad, ADDR_PORT_SPLIT)   ? split_ff :
        hit(ad, ADDR_GLOBAL_SPLIT) ? glob_ff  :
        hit(ad, ADDR_P3_PINSEL)    ? p3sel_ff :
        hit(ad, ADDR_P4_PINSEL)    ? p4sel_ff :
        hit(ad, ADDR_OC_STATUS)    ? oc_byte  :
        hit(ad, ADDR_PWR_ENABLE)   ? pwr_byte : RST_ZERO;
    always_ff @(posedge mclk) begin
        if (srst) rdata_ff <= RST_ZERO;
        else if (cfg_req.rd) rdata_ff <= rd_mux;
    end
    assign cfg_rdata = rdata_ff;

    always_ff @(posedge mclk) begin
        if (srst) begin
            s1_ff    <= '1;
            s2_ff    <= '1;
            sspwr_ff <= '0;
        end else begin
            s1_ff    <= sense_in;
            s2_ff    <= s1_ff;
            sspwr_ff <= ss_pwr_req;
        end
    end

    assign tim.lockout    = lock_ff;
    assign tim.dbl_window = win_ff;
    assign tim.min_width  = minw_ff[3:0];

    ppo_tick #(.CYCLES(TICKC)) u_tick (
        .mclk (mclk),
        .srst (srst),
        .tick (tick)
    );

    generate
        for (genvar p = 0; p < NPORT; p++) begin : g_port
            // the pin only ever governs the 2.0 side on a split port
            ppo_port u_port (
                .mclk     (mclk),
                .srst     (srst),
                .tick     (tick),
                .pwr_en   (pwr_req[p]),
                .pin_low  (!s2_ff[p]),
                .oc_clr   (clr[p]),
                .tim      (tim),
                .oc_flag  (oc_flag[p]),
                .oc_event (oc_event[p])
            );
            assign sense_out[p]    = 1'b0;
            assign sense_oe[p]     = !pwr_req[p];
            assign sense_pullup[p] = pwr_req[p];
        end
    endgenerate

    // split outputs are push-pull and never sampled
    wire p3_on = p3_split && sspwr_ff[PORT3_IDX];
    wire p4_on = p4_split && sspwr_ff[PORT4_IDX];
    assign port3_pin_option_a = p3_on && (p3sel_ff == SEL_P3_OPT_A);
    assign port3_pin_option_b = p3_on && (p3sel_ff == SEL_P3_OPT_B);
    assign port4_pin_option_a = p4_on && (p4sel_ff == SEL_P4_OPT_A);
    assign port4_pin_option_b = p4_on && (p4sel_ff == SEL_P4_OPT_B);

    always_comb begin
        split_active = '0;
        split_active[PORT3_IDX] = p3_split;
        split_active[PORT4_IDX] = p4_split;
    end

    drive_low_a: assert property (@(posedge mclk) disable iff (srst)
        !pwr_req[0] |-> sense_oe[0] && !sense_out[0] && !sense_pullup[0])
        else $error("unpowered pin not driven low");
    split_glob_a: assert property (@(posedge mclk) disable iff (srst)
        !glob_ff[0] |-> split_active == '0) else $error("split without global");
    // only the two splittable port positions may ever show split
    wire [NPORT-1:0] split_legal = (NPORT'(1) << PORT3_IDX) | (NPORT'(1) << PORT4_IDX);

    split_p3_a: assert property (@(posedge mclk) disable iff (srst)
        port3_pin_option_a |-> p3sel_ff == SEL_P3_OPT_A && split_ff[BIT_SPLIT_P3])
        else $error("p3 a bad");
    split_p4_a: assert property (@(posedge mclk) disable iff (srst)
        port4_pin_option_b |-> p4sel_ff == SEL_P4_OPT_B && split_ff[BIT_SPLIT_P4])
        else $error("p4 b bad");
    split_only_a: assert property (@(posedge mclk) disable iff (srst)
        (split_active & ~split_legal) == '0) else $error("split on wrong port");
    reset_zero_a: assert property (@(posedge mclk)
        srst |=> split_ff == RST_ZERO && glob_ff == RST_ZERO) else $error("split reset");
    cv_split3: cover property (@(posedge mclk) port3_pin_option_a);
    cv_split4: cover property (@(posedge mclk) port4_pin_option_b);
    cv_oc: cover property (@(posedge mclk) oc_event != '0);
endmodule
`default_nettype wire

// ===== sim/ppo_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppo_switch_model #(
    parameter int NPORT = 6
) (
    input  wire logic             mclk,      // clock for floating pattern
    input  wire logic [NPORT-1:0] s_out,     // device drive level
    input  wire logic [NPORT-1:0] s_oe,      // device drives pin
    input  wire logic [NPORT-1:0] s_pu,      // device pull-up on
    input  wire logic [NPORT-1:0] fault,     // switch flags overcurrent
    output logic      [NPORT-1:0] s_in       // resolved pin level
);
    // loads are fixed embedded devices, never an open connector
    // fuse wiring: power-good delay taken as zero, pin valid at once
    logic flt_ff = 1'b0;
    always @(posedge mclk) flt_ff <= ~flt_ff;
    // open-drain flag or opened fuse wins over the pull-up
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            if (s_oe[i])
                s_in[i] = s_out[i];
            else if (fault[i])
                s_in[i] = 1'b0;
            else if (s_pu[i])
                s_in[i] = 1'b1;
            else
                s_in[i] = flt_ff;  // undriven pin has no stable level
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_port_power_overcurrent_split.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_port_power_overcurrent_split;
    import ppo_pkg::*;
    localparam int TCK = 20;
    logic mclk, srst, p3a, p3b, p4a, p4b;
    ppo_req_s cfg_req;
    logic [7:0] cfg_rdata;
    logic [5:0] pwr_req, ss_req, s_in, s_out, s_oe, s_pu, split_active, oc_flag, oc_ev, fault;
    int miscompares, samples_checked, ev_cnt;
    logic [7:0] p3sel[3] = '{8'h42, 8'h05, 8'h11};
    logic [7:0] p4sel[3] = '{8'h06, 8'h04, 8'h11};
    logic [1:0] exps[3] = '{2'b10, 2'b01, 2'b00};
    ppo_top #(.NPORT(6), .TICKC(TCK)) uut (.mclk(mclk), .srst(srst), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .pwr_req(pwr_req), .ss_pwr_req(ss_req), .sense_in(s_in),
        .sense_out(s_out), .sense_oe(s_oe), .sense_pullup(s_pu), .port3_pin_option_a(p3a),
        .port3_pin_option_b(p3b), .port4_pin_option_a(p4a), .port4_pin_option_b(p4b),
        .split_active(split_active), .oc_flag(oc_flag), .oc_event(oc_ev));
    ppo_switch_model #(.NPORT(6)) partner (.mclk(mclk), .s_out(s_out), .s_oe(s_oe),
        .s_pu(s_pu), .fault(fault), .s_in(s_in));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(negedge mclk) if (oc_ev[0] === 1'b1) ev_cnt++;
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk) cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk) cfg_req = '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge mclk) cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk) cfg_req = '0;
        `CHK(cfg_rdata, e)
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_flag(input int p);
        for (int i = 0; i < 300; i++) begin
            if (oc_flag[p] === 1'b1)
                return;
            cyc(1);
        end
        miscompares++;
        $display("FAIL t=%0t no overcurrent flag", $time);
        report_and_stop();
    endtask
    task automatic pulse(input int n);
        fault[0] = 1'b1;
        cyc(n);
        fault[0] = 1'b0;
    endtask
    initial begin
        srst = 1'b1;
        cfg_req = '0;
        pwr_req = '0;
        ss_req = '0;
        fault = '0;
        miscompares = 0;
        samples_checked = 0;
        ev_cnt = 0;
        repeat (3) @(posedge mclk);
        @(negedge mclk) srst = 1'b0;
        rd(ADDR_LOCKOUT, 8'h0a);
        rd(ADDR_DBL_WINDOW, 8'h14);
        rd(ADDR_PORT_SPLIT, 8'h00);
        rd(ADDR_GLOBAL_SPLIT, 8'h00);
        rd(16'h0000, 8'h00);
        wr(ADDR_PORT_SPLIT, 8'hff);
        rd(ADDR_PORT_SPLIT, 8'h60);
        wr(ADDR_GLOBAL_SPLIT, 8'hff);
        rd(ADDR_GLOBAL_SPLIT, 8'h01);
        $display("test registers done");
        // split setup during configuration, before any port is powered
        wr(ADDR_GLOBAL_SPLIT, 8'h00);
        ss_req = '1;
        wr(ADDR_P3_PINSEL, 8'h42);
        cyc(2);
        `CHK(split_active, 6'h00)
        `CHK(p3a, 1'b0)
        wr(ADDR_GLOBAL_SPLIT, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_P3_PINSEL, p3sel[i]);
            wr(ADDR_P4_PINSEL, p4sel[i]);
            cyc(2);
            `CHK(split_active, 6'b001100)
            `CHK({p3a, p3b}, exps[i])
            `CHK({p4a, p4b}, exps[i])
        end
        `CHK(s_oe[2], 1'b1)
        $display("test split done");
        `CHK(s_out, 6'h00)
        `CHK(s_oe, 6'h3f)
        `CHK(s_pu, 6'h00)
        wr(ADDR_LOCKOUT, 8'h03);
        wr(ADDR_MIN_WIDTH, 8'h01);
        wr(ADDR_DBL_WINDOW, 8'h02);
        fault[1] = 1'b1;
        @(negedge mclk) pwr_req[0] = 1'b1;
        cyc(1);
        `CHK(s_oe, 6'h3e)
        `CHK(s_pu, 6'h01)
        pulse(30);
        cyc(5);
        `CHK(oc_flag[0], 1'b0)
        rd(ADDR_PWR_ENABLE, 8'h01);
        cyc(80);
        // held low, one group only, so only the width path can fire
        fault[0] = 1'b1;
        wait_flag(0);
        fault[0] = 1'b0;
        `CHK(ev_cnt, 1)
        cyc(30);
        `CHK(oc_flag[0], 1'b1)
        rd(ADDR_OC_STATUS, 8'h01);
        wr(ADDR_OC_STATUS, 8'h01);
        cyc(2);
        `CHK(oc_flag[0], 1'b0)
        $display("test single pulse done");
        wr(ADDR_MIN_WIDTH, 8'h35);
        rd(ADDR_MIN_WIDTH, 8'h05);
        pulse(3);
        cyc(10);
        fault[0] = 1'b1;
        wait_flag(0);
        fault[0] = 1'b0;
        cyc(3);
        `CHK(ev_cnt, 2)
        wr(ADDR_OC_STATUS, 8'h01);
        // let the window from the last pair close before a fresh pair
        cyc(60);
        `CHK(oc_flag[0], 1'b0)
        pulse(3);
        cyc(150);
        pulse(3);
        cyc(20);
        `CHK(oc_flag[0], 1'b0)
        `CHK(oc_flag[1], 1'b0)
        $display("test double pulse done");
        report_and_stop();
    end
endmodule
`default_nettype wire
